//--- shared/rocc_regs.svh
// Register map, field positions, reset values and timing counts
`ifndef ROCC_REGS_SVH
`define ROCC_REGS_SVH
`define ROCC_OFF_CTRL 8'h00
`define ROCC_OFF_REREAD 8'h04
`define ROCC_OFF_TIMEOUT 8'h08
`define ROCC_OFF_INT_RATE 8'h0c
`define ROCC_OFF_MOD_RATE 8'h10
`define ROCC_OFF_IN_DLM 8'h14
`define ROCC_OFF_OUT_DLM 8'h18
`define ROCC_OFF_KW_DLM 8'h1c
`define ROCC_OFF_KW_SEP 8'h20
`define ROCC_OFF_ECHO 8'h24
`define ROCC_OFF_STATUS 8'h28
`define ROCC_OFF_LAST_ID 8'h2c
`define ROCC_CTRL_DISP 0
`define ROCC_CTRL_KW 1
`define ROCC_CTRL_RPT 2
`define ROCC_CTRL_NORD 3
`define ROCC_CTRL_DBL 4
`define ROCC_CTRL_MODE_LO 8
`define ROCC_ECHO_START 8
`define ROCC_RST_TIMEOUT 8'h0f
`define ROCC_RST_REREAD 6'h00
`define ROCC_RATE_MAX 3'h7
`define ROCC_RST_DLM 16'h0d0a
`define ROCC_RST_KW_DLM 16'h0028
`define ROCC_RST_KW_SEP 16'h002c
`define ROCC_ECHO_DISP_CHARS 8'h14
`define ROCC_REREAD_MAX 6'h3f
`define ROCC_TIMEOUT_MAX 8'hff
`define ROCC_CLK_HZ 20000000
`define ROCC_TICK_MS 100
`define ROCC_RESP_OKAY 2'b00
`define ROCC_RESP_SLVERR 2'b10
`endif

//--- shared/rocc_pkg.sv
// Types for the reader output configuration block
package rocc_pkg;
   typedef enum logic [2:0] {
      ROCC_SRC_CONT = 3'b001,
      ROCC_SRC_GT = 3'b010,
      ROCC_SRC_GTC = 3'b100
   } rocc_src_e;

   typedef struct packed {
      logic [7:0] awaddr;
      logic awvalid;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic wvalid;
      logic bready;
      logic [7:0] araddr;
      logic arvalid;
      logic rready;
   } rocc_axi_req_s;

   typedef struct packed {
      logic awready;
      logic wready;
      logic [1:0] bresp;
      logic bvalid;
      logic arready;
      logic [31:0] rdata;
      logic [1:0] rresp;
      logic rvalid;
   } rocc_axi_rsp_s;

   typedef struct packed {
      logic valid;
      logic [31:0] id;
      rocc_src_e src;
      logic noread_end;
   } rocc_read_s;

   typedef struct packed {
      logic disp_valid;
      logic [7:0] disp_char;
      logic kw_valid;
      logic [7:0] kw_char;
      logic virtual_serial_port_valid;
      logic [7:0] virtual_serial_port_char;
   } rocc_echo_s;

   typedef struct packed {
      logic valid;
      logic [31:0] id;
      logic to_display;
      logic to_keystroke;
      logic noread;
   } rocc_report_s;

   typedef struct packed {
      logic display_en;
      logic keystroke_en;
      logic [2:0] internal_rate;
      logic [2:0] module_rate;
      logic [15:0] in_dlm;
      logic [15:0] out_dlm;
      logic [15:0] kw_dlm;
      logic [15:0] kw_sep;
   } rocc_cfg_s;

   typedef struct packed {
      rocc_axi_rsp_s rsp;
      logic aw_have;
      logic [7:0] aw_addr;
      logic w_have;
      logic [31:0] w_data;
      rocc_cfg_s cfg;
      logic rpt_supp;
      logic nord_supp;
      logic dbl_chk;
      logic [2:0] mode;
      logic [5:0] reread;
      logic [7:0] timeout;
      logic [31:0] last_id;
      logic lock;
      logic [31:0] prev_raw;
      logic prev_ok;
      logic [20:0] tick_cnt;
      logic [5:0] dly_cnt;
      logic [7:0] rep_cnt;
      logic [7:0] echo_cnt;
      rocc_echo_s echo;
      rocc_report_s rep;
   } rocc_state_s;
endpackage

//--- rtl/rocc_core.sv
// Reader output configuration and transponder report filter
//
// Added by the designer: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
`include "rocc_regs.svh"

module rocc_core #(
   parameter int unsigned TICK_CYCLES = `ROCC_CLK_HZ / 1000 * `ROCC_TICK_MS
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire rocc_pkg::rocc_axi_req_s axi_req,
   output rocc_pkg::rocc_axi_rsp_s axi_rsp,
   input wire rocc_pkg::rocc_read_s read_in,
   output rocc_pkg::rocc_report_s report,
   output rocc_pkg::rocc_echo_s echo_out,
   output rocc_pkg::rocc_cfg_s cfg
);
   import rocc_pkg::*;

   rocc_state_s s_q;
   rocc_state_s s_d;

   function automatic logic [31:0] rd_mux(input rocc_state_s s,
                                          input logic [7:0] a,
                                          output logic hit);
      logic [31:0] v;
      v = 32'h0;
      hit = 1'b1;
      unique case (a)
         `ROCC_OFF_CTRL: begin
            v[`ROCC_CTRL_DISP] = s.cfg.display_en;
            v[`ROCC_CTRL_KW] = s.cfg.keystroke_en;
            v[`ROCC_CTRL_RPT] = s.rpt_supp;
            v[`ROCC_CTRL_NORD] = s.nord_supp;
            v[`ROCC_CTRL_DBL] = s.dbl_chk;
            v[`ROCC_CTRL_MODE_LO +: 3] = s.mode;
         end
         `ROCC_OFF_REREAD: v[5:0] = s.reread;
         `ROCC_OFF_TIMEOUT: v[7:0] = s.timeout;
         `ROCC_OFF_INT_RATE: v[2:0] = s.cfg.internal_rate;
         `ROCC_OFF_MOD_RATE: v[2:0] = s.cfg.module_rate;
         `ROCC_OFF_IN_DLM: v[15:0] = s.cfg.in_dlm;
         `ROCC_OFF_OUT_DLM: v[15:0] = s.cfg.out_dlm;
         `ROCC_OFF_KW_DLM: v[15:0] = s.cfg.kw_dlm;
         `ROCC_OFF_KW_SEP: v[15:0] = s.cfg.kw_sep;
         `ROCC_OFF_ECHO: v[7:0] = s.echo_cnt;
         `ROCC_OFF_STATUS: begin
            v[0] = s.cfg.internal_rate != s.cfg.module_rate;
            v[1] = s.lock;
            v[2] = s.prev_ok;
            v[15:8] = s.echo_cnt;
         end
         `ROCC_OFF_LAST_ID: v = s.last_id;
         default: hit = 1'b0;
      endcase
      return v;
   endfunction

   always_comb begin
      logic hit;
      logic [31:0] rv;
      logic [31:0] wd;
      logic good;
      logic same;
      logic send;
      logic paced;
      logic tick;
      hit = 1'b0;
      rv = 32'h0;
      wd = s_q.w_data;
      good = 1'b0;
      same = 1'b0;
      send = 1'b0;
      paced = 1'b0;
      tick = 1'b0;
      s_d = s_q;

      // Pulses live one cycle
      s_d.echo.disp_valid = 1'b0;
      s_d.echo.kw_valid = 1'b0;
      s_d.echo.virtual_serial_port_valid = 1'b0;
      s_d.rep.valid = 1'b0;
      s_d.rep.to_display = 1'b0;
      s_d.rep.to_keystroke = 1'b0;
      s_d.rep.noread = 1'b0;

      // Write address and data may arrive in either order
      if (axi_req.awvalid && s_q.rsp.awready) begin
         s_d.aw_have = 1'b1;
         s_d.aw_addr = axi_req.awaddr;
         s_d.rsp.awready = 1'b0;
      end
      if (axi_req.wvalid && s_q.rsp.wready) begin
         s_d.w_have = 1'b1;
         s_d.w_data = axi_req.wdata;
         s_d.rsp.wready = 1'b0;
      end
      if (s_q.rsp.bvalid && axi_req.bready) begin
         s_d.rsp.bvalid = 1'b0;
         s_d.rsp.awready = 1'b1;
         s_d.rsp.wready = 1'b1;
      end

      // Byte strobes ignored: every field sits in one write
      if (s_q.aw_have && s_q.w_have) begin
         s_d.aw_have = 1'b0;
         s_d.w_have = 1'b0;
         s_d.rsp.bvalid = 1'b1;
         s_d.rsp.bresp = `ROCC_RESP_OKAY;
         unique case (s_q.aw_addr)
            `ROCC_OFF_CTRL: begin
               s_d.cfg.display_en = wd[`ROCC_CTRL_DISP];
               s_d.cfg.keystroke_en = wd[`ROCC_CTRL_KW];
               s_d.rpt_supp = wd[`ROCC_CTRL_RPT];
               s_d.nord_supp = wd[`ROCC_CTRL_NORD];
               s_d.dbl_chk = wd[`ROCC_CTRL_DBL];
               s_d.mode = wd[`ROCC_CTRL_MODE_LO +: 3];
            end
            `ROCC_OFF_REREAD: s_d.reread = wd[5:0];
            `ROCC_OFF_TIMEOUT: s_d.timeout = wd[7:0];
            `ROCC_OFF_INT_RATE: s_d.cfg.internal_rate = wd[2:0];
            `ROCC_OFF_MOD_RATE: s_d.cfg.module_rate = wd[2:0];
            `ROCC_OFF_IN_DLM: s_d.cfg.in_dlm = wd[15:0];
            `ROCC_OFF_OUT_DLM: s_d.cfg.out_dlm = wd[15:0];
            `ROCC_OFF_KW_DLM: s_d.cfg.kw_dlm = wd[15:0];
            `ROCC_OFF_KW_SEP: s_d.cfg.kw_sep = wd[15:0];
            `ROCC_OFF_ECHO: begin
               if (wd[`ROCC_ECHO_START]) begin
                  s_d.echo_cnt = 8'h00;
               end else begin
                  // Serial port always gets the full text
                  s_d.echo.virtual_serial_port_valid = 1'b1;
                  s_d.echo.virtual_serial_port_char = wd[7:0];
                  if (s_q.cfg.display_en && s_q.cfg.keystroke_en) begin
                     s_d.echo.kw_valid = 1'b1;
                     s_d.echo.kw_char = wd[7:0];
                     if (s_q.echo_cnt < `ROCC_ECHO_DISP_CHARS) begin
                        s_d.echo.disp_valid = 1'b1;
                        s_d.echo.disp_char = wd[7:0];
                     end
                  end
                  if (s_q.echo_cnt != 8'hff) begin
                     s_d.echo_cnt = s_q.echo_cnt + 8'h01;
                  end
               end
            end
            default: begin
               rv = rd_mux(s_q, s_q.aw_addr, hit);
               // Read-only register: write ignored, unmapped refused
               s_d.rsp.bresp = hit ? `ROCC_RESP_OKAY : `ROCC_RESP_SLVERR;
            end
         endcase
      end

      // One read at a time; answer one cycle after it is taken
      if (s_q.rsp.rvalid && axi_req.rready) begin
         s_d.rsp.rvalid = 1'b0;
         s_d.rsp.arready = 1'b1;
      end
      if (axi_req.arvalid && s_q.rsp.arready) begin
         rv = rd_mux(s_q, axi_req.araddr, hit);
         s_d.rsp.arready = 1'b0;
         s_d.rsp.rvalid = 1'b1;
         s_d.rsp.rdata = rv;
         s_d.rsp.rresp = hit ? `ROCC_RESP_OKAY : `ROCC_RESP_SLVERR;
      end

      // 100 ms time base shared by both delays
      if (s_q.tick_cnt == 21'(TICK_CYCLES - 1)) begin
         s_d.tick_cnt = 21'h0;
         tick = 1'b1;
      end else begin
         s_d.tick_cnt = s_q.tick_cnt + 21'h1;
      end
      if (tick && s_q.dly_cnt != `ROCC_REREAD_MAX) begin
         s_d.dly_cnt = s_q.dly_cnt + 6'h01;
      end
      if (tick && s_q.rep_cnt != `ROCC_TIMEOUT_MAX) begin
         s_d.rep_cnt = s_q.rep_cnt + 8'h01;
      end

      if (read_in.valid) begin
         if (s_q.dbl_chk) begin
            // Continuous get and mode four cannot pair reads
            if (read_in.src == ROCC_SRC_GTC || s_q.mode == 3'h4) begin
               good = 1'b0;
               s_d.prev_ok = 1'b0;
            end else begin
               good = s_q.prev_ok && s_q.prev_raw == read_in.id;
               s_d.prev_raw = read_in.id;
               s_d.prev_ok = !good;
            end
         end else begin
            good = 1'b1;
         end
         same = s_q.lock && s_q.last_id == read_in.id;
         paced = s_q.mode == 3'h2 || s_q.mode == 3'h4;
         if (!good) begin
            send = 1'b0;
         end else if (s_q.rpt_supp) begin
            // Zero delay never releases the same ID
            send = !same || (s_q.reread != 6'h00 &&
                   s_q.dly_cnt >= s_q.reread);
         end else if (paced) begin
            send = !same || s_q.rep_cnt >= s_q.timeout;
         end else begin
            send = 1'b1;
         end
         if (send) begin
            s_d.rep.valid = 1'b1;
            s_d.rep.id = read_in.id;
            s_d.rep.to_display = s_q.cfg.display_en;
            s_d.rep.to_keystroke = s_q.cfg.keystroke_en;
            s_d.last_id = read_in.id;
            s_d.lock = 1'b1;
            s_d.dly_cnt = 6'h00;
            s_d.rep_cnt = 8'h00;
         end
      end
      if (read_in.noread_end && !s_q.nord_supp) begin
         s_d.rep.noread = 1'b1;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_q <= '0;
         s_q.rsp.awready <= 1'b1;
         s_q.rsp.wready <= 1'b1;
         s_q.rsp.arready <= 1'b1;
         s_q.cfg.display_en <= 1'b1;
         s_q.cfg.keystroke_en <= 1'b1;
         s_q.cfg.internal_rate <= `ROCC_RATE_MAX;
         s_q.cfg.module_rate <= `ROCC_RATE_MAX;
         s_q.cfg.in_dlm <= `ROCC_RST_DLM;
         s_q.cfg.out_dlm <= `ROCC_RST_DLM;
         s_q.cfg.kw_dlm <= `ROCC_RST_KW_DLM;
         s_q.cfg.kw_sep <= `ROCC_RST_KW_SEP;
         s_q.timeout <= `ROCC_RST_TIMEOUT;
         s_q.reread <= `ROCC_RST_REREAD;
         s_q.echo.virtual_serial_port_char <= 8'h00;
      end else begin
         s_q <= s_d;
      end
   end

   assign axi_rsp = s_q.rsp;
   assign report = s_q.rep;
   assign echo_out = s_q.echo;
   assign cfg = s_q.cfg;
endmodule

//--- sim/rocc_core_properties.sv
// Port level checks for the reader output configuration block
`timescale 1ns/10ps
module rocc_core_properties #(
   parameter int unsigned TICK_CYCLES = 10
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire rocc_pkg::rocc_axi_req_s axi_req,
   input wire rocc_pkg::rocc_axi_rsp_s axi_rsp,
   input wire rocc_pkg::rocc_read_s read_in,
   input wire rocc_pkg::rocc_report_s report,
   input wire rocc_pkg::rocc_echo_s echo_out,
   input wire rocc_pkg::rocc_cfg_s cfg
);
   import rocc_pkg::*;
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);
   sequence s_wr_take;
      axi_req.awvalid && axi_rsp.awready && axi_req.wvalid && axi_rsp.wready;
   endsequence
   sequence s_b_late;
      !axi_rsp.bvalid ##1 axi_rsp.bvalid;
   endsequence
   b_latency_a: assert property (s_wr_take |=> s_b_late)
      else $error("write response late or early");
   b_hold_a: assert property ($fell(axi_rsp.bvalid) |-> $past(axi_req.bready))
      else $error("write response dropped unanswered");
   r_latency_a: assert property (axi_req.arvalid && axi_rsp.arready |=>
      axi_rsp.rvalid) else $error("read response late");
   r_hold_a: assert property ($fell(axi_rsp.rvalid) |-> $past(axi_req.rready))
      else $error("read response dropped unanswered");
   ready_block_a: assert property ((axi_rsp.bvalid |->
      !axi_rsp.awready && !axi_rsp.wready) and
      (axi_rsp.rvalid |-> !axi_rsp.arready))
      else $error("new request taken while answering");
   report_cause_a: assert property (report.valid && !report.noread |->
      $past(read_in.valid) && report.id == $past(read_in.id))
      else $error("report without matching read");
   noread_cause_a: assert property (report.noread |->
      $past(read_in.noread_end)) else $error("no-read without empty cycle");
   route_copy_a: assert property (report.valid |->
      report.to_display == $past(cfg.display_en) &&
      report.to_keystroke == $past(cfg.keystroke_en))
      else $error("report routing differs from enables");
   echo_lines_a: assert property (echo_out.disp_valid |->
      echo_out.kw_valid && echo_out.virtual_serial_port_valid)
      else $error("display echo without other outputs");
   kw_enable_a: assert property (echo_out.kw_valid |-> echo_out.virtual_serial_port_valid &&
      $past(cfg.display_en) && $past(cfg.keystroke_en))
      else $error("keystroke echo while an output is off");
endmodule

bind rocc_core rocc_core_properties #(.TICK_CYCLES(TICK_CYCLES)) u_props (
   .aclk(aclk),
   .aresetn(aresetn),
   .axi_req(axi_req),
   .axi_rsp(axi_rsp),
   .read_in(read_in),
   .report(report),
   .echo_out(echo_out),
   .cfg(cfg)
);

//--- sim/rocc_reader.sv
// Reader module model raising raw reads and empty cycle ends
`timescale 1ns/10ps
module rocc_reader (
   input wire logic aclk,
   output rocc_pkg::rocc_read_s read_in
);
   import rocc_pkg::*;
   initial read_in = '0;
   task automatic send(input logic [31:0] id, input rocc_src_e s,
      input logic nr);
      @(posedge aclk);
      read_in <= '{valid: !nr, id: id, src: s, noread_end: nr};
      @(posedge aclk);
      read_in.valid <= 1'b0;
      read_in.noread_end <= 1'b0;
      // Idle id inverted so a stale value is never mistaken for a read
      read_in.id <= ~id;
   endtask
endmodule

//--- sim/rocc_core_test.sv
// Register bus and report filter tests for the configuration block
`timescale 1ns/10ps
`include "rocc_regs.svh"
module rocc_core_test;
   import rocc_pkg::*;
   localparam rocc_src_e sc = ROCC_SRC_CONT;
   localparam rocc_src_e sg = ROCC_SRC_GT;
   localparam rocc_src_e sgc = ROCC_SRC_GTC;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   rocc_axi_req_s req = '0;
   rocc_axi_rsp_s rsp;
   rocc_read_s ri;
   rocc_report_s rep;
   rocc_echo_s eo;
   rocc_cfg_s cfg;
   int error_cnt = 0;
   int n_checks = 0;
   int cyc = 0;
   int nd = 0;
   int nk = 0;
   int nv = 0;
   logic [7:0] ra [9] = '{`ROCC_OFF_CTRL, `ROCC_OFF_REREAD, `ROCC_OFF_TIMEOUT,
      `ROCC_OFF_INT_RATE, `ROCC_OFF_MOD_RATE, `ROCC_OFF_IN_DLM,
      `ROCC_OFF_OUT_DLM, `ROCC_OFF_KW_DLM, `ROCC_OFF_KW_SEP};
   logic [31:0] rv [9] = '{32'h3, 32'h0, 32'hf, 32'h7, 32'h7, 32'hd0a,
      32'hd0a, 32'h28, 32'h2c};
   always #25 aclk = ~aclk;
   // Short tick keeps the re-read delay test within a few hundred cycles
   rocc_core #(.TICK_CYCLES(10)) dut (.aclk(aclk), .aresetn(aresetn),
      .axi_req(req), .axi_rsp(rsp), .read_in(ri), .report(rep),
      .echo_out(eo), .cfg(cfg));
   rocc_reader u_rdr (.aclk(aclk), .read_in(ri));
   always @(posedge aclk) begin
      cyc <= cyc + 1;
      nd <= nd + eo.disp_valid;
      nk <= nk + eo.kw_valid;
      nv <= nv + eo.virtual_serial_port_valid;
      if (cyc == 5000) begin
         error_cnt++;
         final_report();
      end
   end
   task automatic final_report();
      $display("checks %0d mismatches %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   task automatic chk(input string n, input logic [31:0] e,
      input logic [31:0] g);
      n_checks++;
      if (g !== e) begin
         error_cnt++;
         $display("wrong value %s exp %h got %h", n, e, g);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge aclk);
      req.awaddr <= a;
      req.wdata <= d;
      req.wstrb <= 4'hf;
      req.awvalid <= 1'b1;
      req.wvalid <= 1'b1;
      req.bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (rsp.awready === 1'b1) req.awvalid <= 1'b0;
         if (rsp.wready === 1'b1) req.wvalid <= 1'b0;
      end while (rsp.bvalid !== 1'b1);
      req.bready <= 1'b0;
      chk("bresp", `ROCC_RESP_OKAY, rsp.bresp);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e,
      input logic [1:0] er);
      @(posedge aclk);
      req.araddr <= a;
      req.arvalid <= 1'b1;
      req.rready <= 1'b1;
      do begin
         @(posedge aclk);
         if (rsp.arready === 1'b1) req.arvalid <= 1'b0;
      end while (rsp.rvalid !== 1'b1);
      req.rready <= 1'b0;
      chk("rdata", e, rsp.rdata);
      chk("rresp", er, rsp.rresp);
   endtask
   task automatic rid(input logic [31:0] id, input rocc_src_e s,
      input logic e);
      u_rdr.send(id, s, 1'b0);
      #1;
      chk("report", e, rep.valid);
      if (e) chk("report id", id, rep.id);
   endtask
   task automatic nr(input logic e);
      u_rdr.send(32'h0, sc, 1'b1);
      #1;
      chk("noread", e, rep.noread);
   endtask
   initial begin
      repeat (3) @(posedge aclk);
      aresetn <= 1'b1;
      for (int i = 0; i < 9; i++) rd(ra[i], rv[i], `ROCC_RESP_OKAY);
      rd(8'h40, 32'h0, `ROCC_RESP_SLVERR);
      wr(`ROCC_OFF_INT_RATE, 32'h3);
      chk("int rate", 32'h3, cfg.internal_rate);
      chk("mod rate", 32'h7, cfg.module_rate);
      rd(`ROCC_OFF_STATUS, 32'h1, `ROCC_RESP_OKAY);
      wr(`ROCC_OFF_MOD_RATE, 32'h3);
      chk("mod rate", 32'h3, cfg.module_rate);
      rd(`ROCC_OFF_STATUS, 32'h0, `ROCC_RESP_OKAY);
      wr(`ROCC_OFF_IN_DLM, 32'hd);
      chk("in dlm", 32'hd, cfg.in_dlm);
      chk("out dlm", 32'hd0a, cfg.out_dlm);
      wr(`ROCC_OFF_KW_SEP, 32'h33);
      chk("kw sep", 32'h33, cfg.kw_sep);
      wr(`ROCC_OFF_TIMEOUT, 32'hff);
      rd(`ROCC_OFF_TIMEOUT, 32'hff, `ROCC_RESP_OKAY);
      wr(`ROCC_OFF_REREAD, 32'hff);
      rd(`ROCC_OFF_REREAD, 32'h3f, `ROCC_RESP_OKAY);
      wr(`ROCC_OFF_REREAD, 32'h0);
      $display("test registers done");
      rid(32'ha1, sc, 1'b1);
      chk("to display", 32'h1, rep.to_display);
      rid(32'ha1, sc, 1'b1);
      wr(`ROCC_OFF_CTRL, 32'h7);
      rid(32'hb2, sc, 1'b1);
      rid(32'hb2, sc, 1'b0);
      rid(32'hc3, sc, 1'b1);
      repeat (300) @(posedge aclk);
      rid(32'hc3, sc, 1'b0);
      wr(`ROCC_OFF_REREAD, 32'h2);
      rid(32'hc3, sc, 1'b1);
      rid(32'hc3, sc, 1'b0);
      repeat (40) @(posedge aclk);
      rid(32'hc3, sc, 1'b1);
      $display("test repeat done");
      wr(`ROCC_OFF_CTRL, 32'h3);
      nr(1'b1);
      wr(`ROCC_OFF_CTRL, 32'hb);
      nr(1'b0);
      wr(`ROCC_OFF_CTRL, 32'h13);
      rid(32'hd4, sc, 1'b0);
      rid(32'hd4, sc, 1'b1);
      rid(32'he5, sg, 1'b0);
      rid(32'hf6, sg, 1'b0);
      rid(32'hf6, sg, 1'b1);
      rid(32'ha7, sgc, 1'b0);
      rid(32'ha7, sgc, 1'b0);
      wr(`ROCC_OFF_CTRL, 32'h413);
      rid(32'hb8, sc, 1'b0);
      rid(32'hb8, sc, 1'b0);
      $display("test filters done");
      wr(`ROCC_OFF_CTRL, 32'h2);
      rid(32'hc9, sc, 1'b1);
      chk("to display", 32'h0, rep.to_display);
      wr(`ROCC_OFF_CTRL, 32'h1);
      rid(32'hca, sc, 1'b1);
      chk("to keystroke", 32'h0, rep.to_keystroke);
      wr(`ROCC_OFF_TIMEOUT, 32'h2);
      wr(`ROCC_OFF_CTRL, 32'h203);
      rid(32'hd5, sc, 1'b1);
      rid(32'hd5, sc, 1'b0);
      repeat (40) @(posedge aclk);
      rid(32'hd5, sc, 1'b1);
      $display("test pacing done");
      wr(`ROCC_OFF_CTRL, 32'h3);
      wr(`ROCC_OFF_ECHO, 32'h100);
      for (int i = 0; i < 21; i++) wr(`ROCC_OFF_ECHO, 32'h41 + i);
      repeat (2) @(posedge aclk);
      chk("disp chars", 32'd20, nd);
      chk("kw chars", 32'd21, nk);
      chk("virtual_serial_port chars", 32'd21, nv);
      chk("disp char", 32'h54, eo.disp_char);
      chk("kw char", 32'h55, eo.kw_char);
      rd(`ROCC_OFF_ECHO, 32'd21, `ROCC_RESP_OKAY);
      wr(`ROCC_OFF_CTRL, 32'h1);
      // Restarted count, so only the keystroke enable can hold the display back
      wr(`ROCC_OFF_ECHO, 32'h100);
      wr(`ROCC_OFF_ECHO, 32'h42);
      repeat (2) @(posedge aclk);
      chk("disp chars", 32'd20, nd);
      chk("kw chars", 32'd21, nk);
      chk("virtual_serial_port chars", 32'd22, nv);
      chk("virtual_serial_port char", 32'h42, eo.virtual_serial_port_char);
      rd(`ROCC_OFF_LAST_ID, 32'hd5, `ROCC_RESP_OKAY);
      rd(`ROCC_OFF_STATUS, 32'h102, `ROCC_RESP_OKAY);
      $display("test echo done");
      aresetn <= 1'b0;
      repeat (3) @(posedge aclk);
      aresetn <= 1'b1;
      rd(`ROCC_OFF_CTRL, 32'h3, `ROCC_RESP_OKAY);
      rd(`ROCC_OFF_MOD_RATE, 32'h7, `ROCC_RESP_OKAY);
      rd(`ROCC_OFF_STATUS, 32'h0, `ROCC_RESP_OKAY);
      $display("test reset done");
      final_report();
   end
endmodule
